// >>> rtl/tol_pkg.sv
package tol_pkg;
   // clock and processing cycle
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned PROG_CYCLE_US = 5000;
   localparam int unsigned PROG_CYCLE_CLKS = (CLK_HZ / 1_000_000) * PROG_CYCLE_US;
   // trip delay: one step per processing cycle, 0.000 .. 3600.000 s
   localparam int unsigned TRIP_DELAY_STEP_US = 5000;
   localparam int unsigned TRIP_DELAY_MAX_S = 3600;
   localparam logic [19:0] TRIP_DELAY_MAX =
      20'((TRIP_DELAY_MAX_S * 1000) / (TRIP_DELAY_STEP_US / 1000));
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ALARM1_LEVEL = 8'h04;
   localparam logic [7:0] OFS_ALARM2_LEVEL = 8'h08;
   localparam logic [7:0] OFS_INHIBIT_LEVEL = 8'h0C;
   localparam logic [7:0] OFS_TRIP_LEVEL = 8'h10;
   localparam logic [7:0] OFS_TRIP_DELAY = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   // control bits
   localparam int CTRL_ALARM1_EN = 0;
   localparam int CTRL_ALARM2_EN = 1;
   localparam int CTRL_INHIBIT_EN = 2;
   localparam int CTRL_W = 3;
   // levels in 0.1 % units, 0.0 .. 150.0 %
   localparam int LEVEL_W = 12;
   localparam logic [11:0] LEVEL_MAX = 12'h5DC;
   localparam logic [11:0] ALARM1_LEVEL_RST = 12'h190;
   localparam logic [11:0] ALARM2_LEVEL_RST = 12'h190;
   localparam logic [11:0] INHIBIT_LEVEL_RST = 12'h320;
   localparam logic [11:0] TRIP_LEVEL_RST = 12'h3E8;
   localparam logic [19:0] TRIP_DELAY_RST = 20'h00000;
   // current in 0.001 x rated units
   localparam logic [15:0] CUR_LIGHT_LIMIT = 16'h000A;
   localparam logic [15:0] CUR_HIGH_LIMIT = 16'h07D0;
   // factors in 8.8 fixed point
   localparam logic [15:0] FACTOR_ONE = 16'h0100;
   // status field positions
   localparam int ST_ALARM1 = 0;
   localparam int ST_ALARM2 = 1;
   localparam int ST_INHIBIT = 2;
   localparam int ST_TRIP = 3;
   localparam int ST_START = 4;
   localparam int ST_BLOCKED = 5;
   localparam int ST_COND_LSB = 8;
   localparam int ST_MOTOR_LSB = 12;
   localparam int ST_FAULT_LSB = 16;

   typedef enum logic [2:0] {
      COND_NORMAL = 3'b000,
      COND_ALARM1 = 3'b001,
      COND_ALARM2 = 3'b010,
      COND_INHIBIT = 3'b011,
      COND_TRIP = 3'b100,
      COND_BLOCKED = 3'b101
   } tol_cond_type;

   typedef enum logic [1:0] {
      MOTOR_LIGHT = 2'b00,
      MOTOR_NORMAL = 2'b01,
      MOTOR_OVERLOAD = 2'b10,
      MOTOR_HIGH_OVERLOAD = 2'b11
   } tol_motor_type;
endpackage

// >>> rtl/tol_thermal_overload_stage.sv
// Decided for this implementation: the register offsets and register access over AHB-Lite.
module tol_thermal_overload_stage
   import tol_pkg::*;
#(
   parameter int unsigned PROG_CYCLE_CLKS_P = PROG_CYCLE_CLKS
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // thermal image and measurement
   input wire logic [11:0] thermal_capacity,
   input wire logic [15:0] meas_current,
   input wire logic [15:0] pickup_current,
   input wire logic block_in,
   // setting checks and raw factors
   input wire logic [15:0] service_factor_raw,
   input wire logic service_factor_valid,
   input wire logic [15:0] ambient_k_raw,
   input wire logic ambient_valid,
   input wire logic [15:0] rated_current_raw,
   input wire logic rated_current_valid,
   input wire logic ambient_k_consistent,
   // stage outputs
   output logic alarm1,
   output logic alarm2,
   output logic restart_inhibit,
   output logic trip,
   output logic start,
   output logic blocked,
   output tol_cond_type operating_condition_code,
   output tol_motor_type motor_status,
   output logic [15:0] service_factor,
   output logic [15:0] ambient_k_used,
   output logic [15:0] rated_current_used,
   output logic [3:0] setting_fault_flag
);

   logic [CTRL_W-1:0] ctrl_ff;
   logic [11:0] alarm1_level_ff, alarm2_level_ff, inhibit_level_ff, trip_level_ff;
   logic [19:0] trip_delay_ff;
   logic [17:0] cyc_cnt_ff;
   logic tick;
   logic blk_smp_ff;
   logic start_ff, blocked_ff, trip_ff;
   logic [19:0] delay_cnt_ff;
   logic alarm1_ff, alarm2_ff, inhibit_ff;
   tol_cond_type cond_ff, nxt_cond;
   tol_motor_type motor_ff, nxt_motor;
   logic [15:0] sf_ff, amb_ff, rated_ff;
   logic [3:0] fault_ff;
   logic ph_wr_ff, ph_rd_ff;
   logic [7:0] ph_addr_ff;
   logic [31:0] rdata_ff, nxt_rdata, status_word;
   logic pickup;
   logic [19:0] nxt_delay_cnt;

   // ---------------- processing cycle ----------------
   assign tick = (cyc_cnt_ff == 18'(PROG_CYCLE_CLKS_P - 1));

   always_ff @(posedge clk_sys) begin
      if (reset || tick) begin
         cyc_cnt_ff <= 18'h00000;
      end else begin
         cyc_cnt_ff <= cyc_cnt_ff + 18'h00001;
      end
   end

   // block level held for the whole cycle in blk_smp_ff; the decisions below read block_in at the tick instead
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         blk_smp_ff <= 1'b0;
      end else if (tick) begin
         blk_smp_ff <= block_in;
      end
   end

   // ---------------- level comparators ----------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         alarm1_ff <= 1'b0;
         alarm2_ff <= 1'b0;
         inhibit_ff <= 1'b0;
      end else begin
         alarm1_ff <= ctrl_ff[CTRL_ALARM1_EN] && (thermal_capacity >= alarm1_level_ff);
         alarm2_ff <= ctrl_ff[CTRL_ALARM2_EN] && (thermal_capacity >= alarm2_level_ff);
         inhibit_ff <= ctrl_ff[CTRL_INHIBIT_EN] && (thermal_capacity >= inhibit_level_ff);
      end
   end

   // ---------------- trip pick-up, blocking, delay ----------------
   assign pickup = (thermal_capacity >= trip_level_ff);
   assign nxt_delay_cnt = (delay_cnt_ff < TRIP_DELAY_MAX) ? delay_cnt_ff + 20'h00001
                                                          : delay_cnt_ff;

   // decisions run once per processing cycle, using block_in as it stands at the tick;
   // a block that lands inside the last cycle of the delay is seen at the tick that ends it, in time to stop the trip
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         start_ff <= 1'b0;
         blocked_ff <= 1'b0;
         trip_ff <= 1'b0;
         delay_cnt_ff <= 20'h00000;
      end else if (tick) begin
         if (!pickup) begin
            start_ff <= 1'b0;
            blocked_ff <= 1'b0;
            trip_ff <= 1'b0;
            delay_cnt_ff <= 20'h00000;
         end else if (block_in) begin
            start_ff <= 1'b0;
            blocked_ff <= 1'b1;
            trip_ff <= 1'b0;
            delay_cnt_ff <= 20'h00000;
         end else begin
            start_ff <= 1'b1;
            blocked_ff <= 1'b0;
            delay_cnt_ff <= start_ff ? nxt_delay_cnt : 20'h00000;
            trip_ff <= start_ff ? (nxt_delay_cnt >= trip_delay_ff)
                                : (trip_delay_ff == 20'h00000);
         end
      end
   end

   // ---------------- condition code and motor status ----------------
   always_comb begin
      if (trip_ff) begin
         nxt_cond = COND_TRIP;
      end else if (blocked_ff) begin
         nxt_cond = COND_BLOCKED;
      end else if (inhibit_ff) begin
         nxt_cond = COND_INHIBIT;
      end else if (alarm2_ff) begin
         nxt_cond = COND_ALARM2;
      end else if (alarm1_ff) begin
         nxt_cond = COND_ALARM1;
      end else begin
         nxt_cond = COND_NORMAL;
      end
   end

   always_comb begin
      if (meas_current < CUR_LIGHT_LIMIT) begin
         nxt_motor = MOTOR_LIGHT;
      end else if (meas_current > CUR_HIGH_LIMIT) begin
         nxt_motor = MOTOR_HIGH_OVERLOAD;
      end else if (meas_current > pickup_current) begin
         nxt_motor = MOTOR_OVERLOAD;
      end else begin
         nxt_motor = MOTOR_NORMAL;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cond_ff <= COND_NORMAL;
         motor_ff <= MOTOR_LIGHT;
      end else begin
         cond_ff <= nxt_cond;
         motor_ff <= nxt_motor;
      end
   end

   // ---------------- setting faults ----------------
   // flags track the checks live, so they vanish as soon as the setting is fixed
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sf_ff <= FACTOR_ONE;
         amb_ff <= FACTOR_ONE;
         rated_ff <= FACTOR_ONE;
         fault_ff <= 4'h0;
      end else begin
         sf_ff <= service_factor_valid ? service_factor_raw : FACTOR_ONE;
         amb_ff <= ambient_valid ? ambient_k_raw : FACTOR_ONE;
         rated_ff <= rated_current_valid ? rated_current_raw : FACTOR_ONE;
         fault_ff <= {!ambient_k_consistent, !rated_current_valid, !ambient_valid,
                      !service_factor_valid};
      end
   end

   // ---------------- ahb-lite slave ----------------
   // zero wait states: read data is prepared at the address edge
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ph_wr_ff <= 1'b0;
         ph_rd_ff <= 1'b0;
         ph_addr_ff <= 8'h00;
      end else if (hready) begin
         ph_wr_ff <= hsel && htrans[1] && hwrite;
         ph_rd_ff <= hsel && htrans[1] && !hwrite;
         ph_addr_ff <= haddr[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrl_ff <= 3'b000;
         alarm1_level_ff <= ALARM1_LEVEL_RST;
         alarm2_level_ff <= ALARM2_LEVEL_RST;
         inhibit_level_ff <= INHIBIT_LEVEL_RST;
         trip_level_ff <= TRIP_LEVEL_RST;
         trip_delay_ff <= TRIP_DELAY_RST;
      end else if (ph_wr_ff) begin
         unique case (ph_addr_ff)
            OFS_CTRL: begin
               ctrl_ff <= hwdata[CTRL_W-1:0];
            end
            OFS_ALARM1_LEVEL: begin
               alarm1_level_ff <= (hwdata[11:0] > LEVEL_MAX) ? LEVEL_MAX : hwdata[11:0];
            end
            OFS_ALARM2_LEVEL: begin
               alarm2_level_ff <= (hwdata[11:0] > LEVEL_MAX) ? LEVEL_MAX : hwdata[11:0];
            end
            OFS_INHIBIT_LEVEL: begin
               inhibit_level_ff <= (hwdata[11:0] > LEVEL_MAX) ? LEVEL_MAX : hwdata[11:0];
            end
            OFS_TRIP_LEVEL: begin
               trip_level_ff <= (hwdata[11:0] > LEVEL_MAX) ? LEVEL_MAX : hwdata[11:0];
            end
            OFS_TRIP_DELAY: begin
               trip_delay_ff <= (hwdata[19:0] > TRIP_DELAY_MAX) ? TRIP_DELAY_MAX
                                                                : hwdata[19:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      status_word = 32'h00000000;
      status_word[ST_ALARM1] = alarm1_ff;
      status_word[ST_ALARM2] = alarm2_ff;
      status_word[ST_INHIBIT] = inhibit_ff;
      status_word[ST_TRIP] = trip_ff;
      status_word[ST_START] = start_ff;
      status_word[ST_BLOCKED] = blocked_ff;
      status_word[ST_COND_LSB +: 3] = cond_ff;
      status_word[ST_MOTOR_LSB +: 2] = motor_ff;
      status_word[ST_FAULT_LSB +: 4] = fault_ff;
   end

   always_comb begin
      nxt_rdata = 32'h00000000;
      unique case (haddr[7:0])
         OFS_CTRL: nxt_rdata = {29'h00000000, ctrl_ff};
         OFS_ALARM1_LEVEL: nxt_rdata = {20'h00000, alarm1_level_ff};
         OFS_ALARM2_LEVEL: nxt_rdata = {20'h00000, alarm2_level_ff};
         OFS_INHIBIT_LEVEL: nxt_rdata = {20'h00000, inhibit_level_ff};
         OFS_TRIP_LEVEL: nxt_rdata = {20'h00000, trip_level_ff};
         OFS_TRIP_DELAY: nxt_rdata = {12'h000, trip_delay_ff};
         OFS_STATUS: nxt_rdata = status_word;
         default: nxt_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdata_ff <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = ph_rd_ff ? rdata_ff : 32'h00000000;

   // ---------------- outputs ----------------
   assign alarm1 = alarm1_ff;
   assign alarm2 = alarm2_ff;
   assign restart_inhibit = inhibit_ff;
   assign trip = trip_ff;
   assign start = start_ff;
   assign blocked = blocked_ff;
   assign operating_condition_code = cond_ff;
   assign motor_status = motor_ff;
   assign service_factor = sf_ff;
   assign ambient_k_used = amb_ff;
   assign rated_current_used = rated_ff;
   assign setting_fault_flag = fault_ff;

   // ---------------- assertions ----------------
   a_alarm1_disabled: assert property (@(posedge clk_sys) disable iff (reset)
      !ctrl_ff[CTRL_ALARM1_EN] |=> !alarm1_ff)
      else $error("first alarm asserted while disabled");

   a_alarm1_level_hit: assert property (@(posedge clk_sys) disable iff (reset)
      (ctrl_ff[CTRL_ALARM1_EN] && thermal_capacity >= alarm1_level_ff) |=> alarm1_ff)
      else $error("first alarm missed its level");

   a_alarm2_level_drop: assert property (@(posedge clk_sys) disable iff (reset)
      (thermal_capacity < alarm2_level_ff) |=> !alarm2_ff)
      else $error("second alarm held below its level");

   a_inhibit_level_hit: assert property (@(posedge clk_sys) disable iff (reset)
      (ctrl_ff[CTRL_INHIBIT_EN] && thermal_capacity >= inhibit_level_ff) |=> inhibit_ff)
      else $error("restart inhibit missed its level");

   a_trip_needs_start: assert property (@(posedge clk_sys) disable iff (reset)
      trip_ff |-> start_ff && (delay_cnt_ff >= trip_delay_ff || trip_delay_ff == 20'h00000))
      else $error("trip without elapsed delay");

   a_block_sample_hold: assert property (@(posedge clk_sys) disable iff (reset)
      !tick |=> $stable(blk_smp_ff))
      else $error("block sample changed mid cycle");

   a_block_clears_start: assert property (@(posedge clk_sys) disable iff (reset)
      (tick && block_in) |=> !start_ff && !trip_ff && delay_cnt_ff == 20'h00000)
      else $error("start survived an active block");

   a_blocked_no_start: assert property (@(posedge clk_sys) disable iff (reset)
      blocked_ff |-> !start_ff)
      else $error("blocked and start together");

   a_normal_no_outputs: assert property (@(posedge clk_sys) disable iff (reset)
      (cond_ff == COND_NORMAL) |-> $past(!alarm1_ff && !alarm2_ff && !inhibit_ff && !trip_ff))
      else $error("normal code with an output active");

   a_light_load_status: assert property (@(posedge clk_sys) disable iff (reset)
      (meas_current < CUR_LIGHT_LIMIT) |=> motor_ff == MOTOR_LIGHT)
      else $error("light load not reported");

   a_sf_override_one: assert property (@(posedge clk_sys) disable iff (reset)
      !service_factor_valid |=> fault_ff[0] && sf_ff == FACTOR_ONE)
      else $error("service factor not forced to one");

endmodule

// >>> verif/tol_far_side.sv
module tol_far_side (
   // clock
   input wire logic clk_sys,
   // settings from the bench
   input wire logic [11:0] cap_cmd,
   input wire logic [15:0] cur_cmd,
   input wire logic [15:0] pick_cmd,
   input wire logic blk_cmd,
   // lines into the stage
   output logic [11:0] thermal_capacity,
   output logic [15:0] meas_current,
   output logic [15:0] pickup_current,
   output logic block_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // lines start low so the stage never sees an unknown before the first edge
   initial begin
      thermal_capacity = 12'h000;
      meas_current = 16'h0000;
      pickup_current = 16'h0000;
      block_in = 1'b0;
   end
   // measurement chain and blocking matrix each add one cycle of latency
   always @(posedge clk_sys) begin
      thermal_capacity <= cap_cmd;
      meas_current <= cur_cmd;
      pickup_current <= pick_cmd;
      block_in <= blk_cmd;
   end
endmodule

// >>> verif/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import tol_pkg::*;
   localparam int unsigned CYC = 8;
   logic clk_sys, reset, hsel, hwrite, hreadyout, hresp, blk_cmd;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic hready;
   logic [11:0] cap_cmd, thermal_capacity;
   logic [15:0] cur_cmd, pick_cmd, meas_current, pickup_current;
   logic block_in, alarm1, alarm2, restart_inhibit, trip, start, blocked;
   logic [3:0] okv, setting_fault_flag;
   logic [15:0] service_factor, ambient_k_used, rated_current_used;
   tol_cond_type cond;
   tol_motor_type motor;
   int n_fail, n_tests, cyc_cnt;
   assign hready = hreadyout;

   tol_thermal_overload_stage #(.PROG_CYCLE_CLKS_P(CYC)) uut (.clk_sys(clk_sys), .reset(reset),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .thermal_capacity(thermal_capacity), .meas_current(meas_current),
      .pickup_current(pickup_current), .block_in(block_in),
      .service_factor_raw(16'h0140), .service_factor_valid(okv[0]),
      .ambient_k_raw(16'h00C0), .ambient_valid(okv[1]), .rated_current_raw(16'h0123),
      .rated_current_valid(okv[2]), .ambient_k_consistent(okv[3]), .alarm1(alarm1),
      .alarm2(alarm2), .restart_inhibit(restart_inhibit), .trip(trip), .start(start),
      .blocked(blocked), .operating_condition_code(cond), .motor_status(motor),
      .service_factor(service_factor), .ambient_k_used(ambient_k_used),
      .rated_current_used(rated_current_used), .setting_fault_flag(setting_fault_flag));

   tol_far_side u_far (.clk_sys(clk_sys), .cap_cmd(cap_cmd), .cur_cmd(cur_cmd),
      .pick_cmd(pick_cmd), .blk_cmd(blk_cmd), .thermal_capacity(thermal_capacity),
      .meas_current(meas_current), .pickup_current(pickup_current), .block_in(block_in));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic complete_run;
      if (n_fail == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // generous ceiling; the whole sequence needs well under 2000 cycles
   always @(posedge clk_sys) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         n_fail++;
         complete_run;
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= 1'b1;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= 1'b0;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      // read data is taken at the edge that ends the data phase
      do @(posedge clk_sys); while (hready !== 1'b1);
      d = hrdata;
   endtask

   // bounded wait until start reaches the wanted level
   task automatic wait_start(input logic lvl);
      int k;
      k = 0;
      while (start !== lvl && k < 6 * CYC) begin
         step(1);
         k++;
      end
      check(start, lvl);
   endtask

   task automatic t_reset_regs;
      logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
      logic [31:0] exp [7] = '{0, 32'h190, 32'h190, 32'h320, 32'h3E8, 0, 0};
      logic [31:0] d;
      for (int i = 0; i < 7; i++) begin
         bus_rd(ofs[i], d);
         check(d, exp[i]);
      end
      bus_wr(8'h04, 32'h00000FFF);
      bus_rd(8'h04, d);
      check(d, 32'h000005DC);
   endtask

   task automatic t_levels;
      logic [11:0] lvl [3] = '{12'h12C, 12'h1F4, 12'h2BC};
      tol_cond_type cx [3] = '{COND_ALARM1, COND_ALARM2, COND_INHIBIT};
      bus_wr(8'h10, 32'h000005DC);
      @(posedge clk_sys);
      cap_cmd <= 12'h578;
      step(4);
      check({alarm1, alarm2, restart_inhibit, trip, start}, 0);
      check(cond, COND_NORMAL);
      bus_wr(8'h04, {20'h0, lvl[0]});
      bus_wr(8'h08, {20'h0, lvl[1]});
      bus_wr(8'h0C, {20'h0, lvl[2]});
      bus_wr(8'h00, 32'h00000007);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys);
         cap_cmd <= lvl[i] - 12'h001;
         step(4);
         check({restart_inhibit, alarm2, alarm1} >> i, 0);
         @(posedge clk_sys);
         cap_cmd <= lvl[i];
         step(4);
         check({restart_inhibit, alarm2, alarm1} >> i, 1);
         check(cond, cx[i]);
      end
   endtask

   task automatic t_trip(input int n);
      int k;
      logic [31:0] d;
      bus_wr(8'h10, 32'h000003E8);
      bus_wr(8'h14, n);
      @(posedge clk_sys);
      cap_cmd <= 12'h000;
      wait_start(1'b0);
      @(posedge clk_sys);
      cap_cmd <= 12'h3E8;
      wait_start(1'b1);
      k = 0;
      while (trip !== 1'b1 && k < 1000) begin
         step(1);
         k++;
      end
      check(k, n * CYC);
      step(1);
      check(cond, COND_TRIP);
      // all three levels are below the capacity here, so alarm1, alarm2, inhibit, trip and start are up, blocked is not
      bus_rd(OFS_STATUS, d);
      check(d, 32'h0000001F | (32'(COND_TRIP) << ST_COND_LSB));
      @(posedge clk_sys);
      cap_cmd <= 12'h3E7;
      wait_start(1'b0);
      check(trip, 0);
   endtask

   task automatic t_block;
      @(posedge clk_sys);
      blk_cmd <= 1'b1;
      cap_cmd <= 12'h3E8;
      step(2 * CYC + 2);
      check({blocked, start, trip}, 3'b100);
      check(cond, COND_BLOCKED);
      @(posedge clk_sys);
      blk_cmd <= 1'b0;
      wait_start(1'b1);
      check(blocked, 0);
      // one-cycle pulse well between two ticks must not be seen
      @(posedge clk_sys);
      blk_cmd <= 1'b1;
      @(posedge clk_sys);
      blk_cmd <= 1'b0;
      step(CYC);
      check({start, blocked}, 2'b10);
      @(posedge clk_sys);
      blk_cmd <= 1'b1;
      step(CYC + 2);
      check(start, 0);
      step(3 * CYC);
      check({trip, start}, 0);
      @(posedge clk_sys);
      blk_cmd <= 1'b0;
      cap_cmd <= 12'h000;
      step(2 * CYC);
   endtask

   task automatic t_motor;
      logic [15:0] cur [5] = '{16'h0009, 16'h000A, 16'h044D, 16'h07D0, 16'h07D1};
      tol_motor_type mx [5] = '{MOTOR_LIGHT, MOTOR_NORMAL, MOTOR_OVERLOAD,
                                MOTOR_OVERLOAD, MOTOR_HIGH_OVERLOAD};
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys);
         pick_cmd <= 16'h044C;
         cur_cmd <= cur[i];
         step(4);
         check(motor, mx[i]);
         check({alarm1, trip}, 0);
      end
   endtask

   task automatic t_faults;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         okv <= 4'hF ^ (4'h1 << i);
         step(4);
         check(setting_fault_flag, 4'h1 << i);
         check(service_factor, (i == 0) ? 16'h0100 : 16'h0140);
         check(ambient_k_used, (i == 1) ? 16'h0100 : 16'h00C0);
         check(rated_current_used, (i == 2) ? 16'h0100 : 16'h0123);
      end
      @(posedge clk_sys);
      okv <= 4'hF;
      step(4);
      check(setting_fault_flag, 0);
   endtask

   initial begin
      reset = 1'b1;
      {hsel, hwrite, blk_cmd} = 3'b000;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      htrans = 2'h0;
      hsize = 3'h2;
      {cap_cmd, cur_cmd, pick_cmd} = '0;
      okv = 4'hF;
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset_regs;
      t_levels;
      t_trip(0);
      t_trip(3);
      t_block;
      t_motor;
      t_faults;
      complete_run;
   end
endmodule
